// ===== core/tas_alarm_status_bank.sv
// Latched alarm, live operating state and priority report registers.
// Assumes loop status, reference status and phase error come from logic
// on clk; composite-clock rail pulses and tone detect come from pins.
//
// What this block does
// - Phase monitor alarm latches when phase error exceeds threshold; write 1 clears.
// - Aux no-input alarm latches; write 1 cannot clear while condition holds.
// - AMI flag sets after two consecutive broken 8-bit mark/BPV periods.
// - Missing BPVs are not violations while the 400 Hz tone is detected.
// - Write 1 clears AMI flag; only a new violation sets it again.
// - Loss flag sets when no pulse arrives within 32 us.
// - Write 1 clears loss flag; only a new valid-to-loss edge sets it.
// - AMI and loss flags work only while that input's format select is 0.
// - Interrupt output asserts while any latched bit that reads as 1 and its enable are set.
// - Operating state bit 7 shows live frame sync monitor alarm.
// - Operating state bit 6 shows live aux loop lock status.
// - Bits 5 and 4 show main and aux frequency outside the 7-bit soft limit.
// - Bits 2 to 0 show the main loop state code.
// - Top nibble of first priority register shows highest valid reference.
// - Priority fields show main loop if view select is 0, else aux loop.
// - References marked invalid by software are never reported.
// - Selected reference is reported as is, never forced to match top priority.
// - Low nibble of first priority register shows selected reference, 0 if none.
// - Top nibble of second priority register shows third valid reference.
// - Low nibble of second priority register shows second valid reference.
`timescale 1ns/1ps

module tas_alarm_status_bank #(
   parameter int NUM_CC = 2
)(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Loop and reference status
   input wire tas_pkg::tas_loop_t loop_status,
   input wire tas_pkg::tas_ref_t main_refs,
   input wire tas_pkg::tas_ref_t aux_refs,
   input wire logic [7:0] phase_error_mag,
   input wire logic aux_loop_no_input,
   // Composite-clock rails, one bit per input
   input wire logic [NUM_CC-1:0] cc_pos,
   input wire logic [NUM_CC-1:0] cc_neg,
   input wire logic [NUM_CC-1:0] cc_tone_400hz,
   // Interrupt
   output logic interrupt_request_out
);

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   logic [7:0] status_r;
   logic [7:0] status_nxt;
   logic [7:0] irq_en_r;
   logic [7:0] ctrl_r;
   logic [13:0] valid_mask_r;
   logic [6:0] soft_limit_r;
   logic [7:0] phase_limit_r;
   logic [7:0] loop_operating_state_r;
   logic [7:0] top_pri_r;
   logic [7:0] pri_23_r;
   logic pready_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic irq_r;
   logic phase_over_r;
   logic fs_alarm_r;
   logic aux_lock_r;

   // -------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------
   logic [9:0] idx;
   logic aligned;
   logic hit_status;
   logic hit_loop_operating_state;
   logic hit_top;
   logic hit_pri23;
   logic hit_irq_en;
   logic hit_ctrl;
   logic hit_vmask;
   logic hit_limits;
   logic hit;
   logic access;
   logic take;
   logic done;
   logic wr;
   logic [7:0] rd_mux;
   logic [7:0] clear_mask;
   logic [7:0] status_view;
   logic [7:0] fmt_mask;

   // Word index and per-register hits
   assign idx = paddr[11:2];
   assign aligned = paddr[1:0] == 2'b00;
   assign hit_status = aligned && idx == tas_pkg::IDX_STATUS3;
   assign hit_loop_operating_state = aligned && idx == tas_pkg::IDX_LOOP_OPERATING_STATE;
   assign hit_top = aligned && idx == tas_pkg::IDX_TOP_PRI;
   assign hit_pri23 = aligned && idx == tas_pkg::IDX_PRI_23;
   assign hit_irq_en = aligned && idx == tas_pkg::IDX_IRQ_EN3;
   assign hit_ctrl = aligned && idx == tas_pkg::IDX_CTRL;
   assign hit_vmask = aligned && idx == tas_pkg::IDX_VALID_MASK;
   assign hit_limits = aligned && idx == tas_pkg::IDX_LIMITS;
   assign hit = hit_status | hit_loop_operating_state | hit_top | hit_pri23 | hit_irq_en
              | hit_ctrl | hit_vmask | hit_limits;

   // Access phase answered one cycle after it starts
   assign access = psel & penable;
   assign take = access & ~pready_r;
   assign done = access & pready_r;
   assign wr = done & pwrite & hit;

   // Flags of an input in pulse-clock mode read and interrupt as zero
   assign fmt_mask = {4'h0,
                      {2{ctrl_r[tas_pkg::CTL_FMT_B]}},
                      {2{ctrl_r[tas_pkg::CTL_FMT_A]}}};
   assign status_view = status_r & ~fmt_mask;

   // Read data selection
   assign rd_mux = hit_status ? status_view :
                   hit_loop_operating_state ? loop_operating_state_r :
                   hit_top ? top_pri_r :
                   hit_pri23 ? pri_23_r :
                   hit_irq_en ? irq_en_r :
                   hit_ctrl ? ctrl_r :
                   hit_vmask ? valid_mask_r[7:0] :
                   hit_limits ? phase_limit_r :
                   8'h00;

   // Only ones written to the status register clear bits
   assign clear_mask = (wr && hit_status) ? pwdata[7:0] : 8'h00;

   // Bus answer
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r <= take;
         pslverr_r <= take & ~hit;
         if (take)
         begin
            prdata_r <= (pwrite || !hit) ? 32'h0000_0000 : {24'h00_0000, rd_mux};
            if (hit_vmask && !pwrite)
               prdata_r <= {18'h0_0000, valid_mask_r};
            if (hit_limits && !pwrite)
               prdata_r <= {17'h0_0000, soft_limit_r, phase_limit_r};
         end
      end
   end

   // -------------------------------------------------------------
   // Software-written configuration
   // -------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         irq_en_r <= tas_pkg::RST_IRQ_EN3;
         ctrl_r <= tas_pkg::RST_CTRL;
         valid_mask_r <= tas_pkg::RST_VALID_MASK;
         soft_limit_r <= tas_pkg::RST_SOFT_LIMIT;
         phase_limit_r <= tas_pkg::RST_PHASE_LIMIT;
      end
      else if (wr)
      begin
         if (hit_irq_en)
            irq_en_r <= pwdata[7:0];
         if (hit_ctrl)
            ctrl_r <= {4'h0, pwdata[3:0]};
         if (hit_vmask)
            valid_mask_r <= pwdata[13:0];
         if (hit_limits)
         begin
            phase_limit_r <= pwdata[7:0];
            soft_limit_r <= pwdata[tas_pkg::LIM_SOFT_LSB +: 7];
         end
      end
   end

   // -------------------------------------------------------------
   // Composite-clock receivers, one per input
   // -------------------------------------------------------------
   logic [NUM_CC-1:0] ami_evt;
   logic [NUM_CC-1:0] loss_evt;

   genvar g;
   generate
      for (g = 0; g < NUM_CC; g++)
      begin : g_cc
         logic [2:0] pos_s;
         logic [2:0] neg_s;
         logic [1:0] tone_s;
         logic pulse;
         logic is_pos;
         logic last_pos_r;
         logic [2:0] marks_r;
         logic bad_prev_r;
         logic bad;
         logic period_end;
         logic [tas_pkg::LOSS_W-1:0] quiet_r;
         logic lost;
         logic lost_r;
         logic enabled;

         // Pin synchronisers; third stage only for edge detection
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               pos_s <= 3'h0;
               neg_s <= 3'h0;
               tone_s <= 2'h0;
            end
            else
            begin
               pos_s <= {pos_s[1:0], cc_pos[g]};
               neg_s <= {neg_s[1:0], cc_neg[g]};
               tone_s <= {tone_s[0], cc_tone_400hz[g]};
            end
         end

         // Mark detection and line-code checks
         assign is_pos = pos_s[1] & ~pos_s[2];
         assign pulse = is_pos | (neg_s[1] & ~neg_s[2]);
         assign enabled = ~ctrl_r[g == 0 ? tas_pkg::CTL_FMT_A : tas_pkg::CTL_FMT_B];
         assign period_end = pulse && (is_pos == last_pos_r
                             || marks_r == tas_pkg::MARKS_PER_BPV);
         // BPV at wrong place, or missing BPV without the tone
         assign bad = (is_pos == last_pos_r) ? marks_r != tas_pkg::MARKS_PER_BPV
                      : ~tone_s[1];
         assign lost = quiet_r >= tas_pkg::LOSS_W'(tas_pkg::SIG_LOSS_CYC);

         // Period counter and violation history
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               last_pos_r <= 1'b0;
               marks_r <= 3'h0;
               bad_prev_r <= 1'b0;
            end
            else if (pulse)
            begin
               last_pos_r <= is_pos;
               marks_r <= period_end ? 3'h0 : marks_r + 3'h1;
               if (period_end)
                  bad_prev_r <= bad;
            end
         end

         // Silent-time counter, saturating at the loss window
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               quiet_r <= '0;
               lost_r <= 1'b0;
            end
            else
            begin
               quiet_r <= pulse ? '0 : (lost ? quiet_r : quiet_r + 1'b1);
               lost_r <= lost;
            end
         end

         // Events only while acting as composite-clock receiver
         assign ami_evt[g] = enabled & period_end & bad & bad_prev_r;
         assign loss_evt[g] = enabled & lost & ~lost_r;
      end
   endgenerate

   // -------------------------------------------------------------
   // Latched status bits
   // -------------------------------------------------------------
   logic phase_over;
   logic [7:0] set_mask;

   assign phase_over = phase_error_mag > phase_limit_r;
   assign set_mask = {loop_status.frame_sync_monitor_alarm & ~fs_alarm_r,
                      loop_status.aux_loop_locked ^ aux_lock_r,
                      phase_over & ~phase_over_r,
                      aux_loop_no_input,
                      ami_evt[1], loss_evt[1],
                      ami_evt[0], loss_evt[0]};

   // Set wins over a clear in the same cycle
   always_comb
   begin
      status_nxt = (status_r & ~clear_mask) | set_mask;
      if (aux_loop_no_input)
         status_nxt[tas_pkg::ST_NO_INPUT] = 1'b1;
   end

   // Status flops and edge history of the live sources
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         status_r <= tas_pkg::RST_STATUS3;
         phase_over_r <= 1'b0;
         fs_alarm_r <= 1'b0;
         aux_lock_r <= 1'b1;
         irq_r <= 1'b0;
      end
      else
      begin
         status_r <= status_nxt;
         phase_over_r <= phase_over;
         fs_alarm_r <= loop_status.frame_sync_monitor_alarm;
         aux_lock_r <= loop_status.aux_loop_locked;
         irq_r <= |(status_view & irq_en_r);
      end
   end

   // -------------------------------------------------------------
   // Live operating state
   // -------------------------------------------------------------
   logic main_soft;
   logic aux_soft;

   // Frequency outside the soft limit raises the soft alarm
   assign main_soft = loop_status.main_freq_mag > {1'b0, soft_limit_r};
   assign aux_soft = loop_status.aux_freq_mag > {1'b0, soft_limit_r};

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         loop_operating_state_r <= tas_pkg::RST_LOOP_OPERATING_STATE;
      else
         loop_operating_state_r <= {loop_status.frame_sync_monitor_alarm,
                       loop_status.aux_loop_locked,
                       main_soft, aux_soft, 1'b0,
                       loop_status.main_loop_state};
   end

   // -------------------------------------------------------------
   // Priority and selected reference report
   // -------------------------------------------------------------
   tas_pkg::tas_ref_t view;
   logic [13:0] eligible;
   logic [3:0] sel_code;
   logic sel_ok;

   // Loop chosen by view select; masked inputs are never eligible
   assign view = ctrl_r[tas_pkg::CTL_VIEW] ? aux_refs : main_refs;
   assign eligible = view.valid & valid_mask_r;
   assign sel_ok = view.selected_ref != tas_pkg::REF_NONE
                   && view.selected_ref != tas_pkg::REF_UNUSED
                   && valid_mask_r[view.selected_ref - 4'h1];
   // Selection passed through untouched, not aligned to top priority
   assign sel_code = sel_ok ? view.selected_ref : tas_pkg::REF_NONE;

   logic [3:0] ref_1;
   logic [3:0] ref_2;
   logic [3:0] ref_3;

   // Lower input number ranks higher; first three eligible are taken
   always_comb
   begin
      logic [1:0] found;
      found = 2'd0;
      ref_1 = tas_pkg::REF_NONE;
      ref_2 = tas_pkg::REF_NONE;
      ref_3 = tas_pkg::REF_NONE;
      for (int i = 0; i < 14; i++)
      begin
         if (eligible[i] && found != 2'd3)
         begin
            case (found)
               2'd0: ref_1 = 4'(i + 1);
               2'd1: ref_2 = 4'(i + 1);
               default: ref_3 = 4'(i + 1);
            endcase
            found = found + 2'd1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         top_pri_r <= tas_pkg::RST_PRI;
         pri_23_r <= tas_pkg::RST_PRI;
      end
      else
      begin
         top_pri_r <= {ref_1, sel_code};
         pri_23_r <= {ref_3, ref_2};
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign pready = pready_r;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;
   assign interrupt_request_out = irq_r;

endmodule

// ===== core/tas_pkg.sv
// Constants, register map and carrier types for the alarm and status bank.
// Assumes a 125 MHz system clock and a 32-bit APB register bus.
package tas_pkg;

   // -------------------------------------------------------------
   // Clock and timing
   // -------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int SIG_LOSS_US = 32; // Silent window before loss of signal
   localparam int SIG_LOSS_CYC = SIG_LOSS_US * CLK_MHZ;
   localparam int LOSS_W = 12;

   // -------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -------------------------------------------------------------
   localparam logic [9:0] IDX_STATUS3 = 10'h008;
   localparam logic [9:0] IDX_LOOP_OPERATING_STATE = 10'h009;
   localparam logic [9:0] IDX_TOP_PRI = 10'h00a;
   localparam logic [9:0] IDX_PRI_23 = 10'h00b;
   localparam logic [9:0] IDX_IRQ_EN3 = 10'h010;
   localparam logic [9:0] IDX_CTRL = 10'h011;
   localparam logic [9:0] IDX_VALID_MASK = 10'h012;
   localparam logic [9:0] IDX_LIMITS = 10'h013;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [7:0] RST_STATUS3 = 8'h50;
   localparam logic [7:0] RST_LOOP_OPERATING_STATE = 8'h41;
   localparam logic [7:0] RST_PRI = 8'h00;
   localparam logic [7:0] RST_IRQ_EN3 = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [13:0] RST_VALID_MASK = 14'h3fff;
   localparam logic [6:0] RST_SOFT_LIMIT = 7'h7f;
   localparam logic [7:0] RST_PHASE_LIMIT = 8'hff;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int ST_FRAME_SYNC = 7;
   localparam int ST_AUX_LOCK = 6;
   localparam int ST_PHASE_MON = 5;
   localparam int ST_NO_INPUT = 4;
   localparam int ST_LOSS_BASE = 0; // Loss flag of input i at 2*i
   localparam int ST_AMI_BASE = 1;  // AMI flag of input i at 2*i+1
   localparam int CTL_FMT_A = 0;
   localparam int CTL_FMT_B = 1;
   localparam int CTL_VIEW = 2;
   localparam int CTL_REVERTIVE_ENABLE = 3;
   localparam int LIM_SOFT_LSB = 8;

   // -------------------------------------------------------------
   // Reference codes and line code
   // -------------------------------------------------------------
   localparam logic [3:0] REF_NONE = 4'h0;
   localparam logic [3:0] REF_UNUSED = 4'hf;
   localparam logic [2:0] MARKS_PER_BPV = 3'h7;
   localparam logic [2:0] MAIN_FREE_RUN = 3'h1;

   // Live loop status from the two DPLLs
   typedef struct packed {
      logic frame_sync_monitor_alarm;
      logic aux_loop_locked;
      logic [7:0] main_freq_mag;
      logic [7:0] aux_freq_mag;
      logic [2:0] main_loop_state;
   } tas_loop_t;

   // Reference status of one loop
   typedef struct packed {
      logic [13:0] valid;
      logic [3:0] selected_ref;
   } tas_ref_t;

endpackage

// ===== verification/tas_alarm_status_bank_sva.sv
// Checker for the alarm and status bank, watching the top-level ports.
// Assumes the operating state read data trails loop status by two edges.
`timescale 1ns/1ps
module tas_alarm_status_bank_sva #(
   parameter int NUM_CC = 2
)(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Live loop status
   input wire tas_pkg::tas_loop_t loop_status
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------
   // Decodes of the watched signals
   // ----------------------------------------
   wire op_rd = pready && !pwrite && !pslverr && paddr == 12'h024;
   wire fs = loop_status.frame_sync_monitor_alarm;
   wire lk = loop_status.aux_loop_locked;
   wire [2:0] st = loop_status.main_loop_state;

   // ----------------------------------------
   // Bus timing and refusals
   // ----------------------------------------
   AST_ACCESS_ANSWER: assert property (psel && penable && !pready |=> pready)
      else $error("no answer after first access edge");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error without pready or with data");
   AST_UNALIGNED: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("unaligned access not refused");
   AST_UNMAPPED: assert property (pready && paddr[11:7] != 5'h0 |-> pslverr)
      else $error("unmapped access not refused");
   // Mask and limits registers are wider than one byte
   AST_UPPER_ZERO: assert property (pready && paddr[11:3] != 9'h009 |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");

   // ----------------------------------------
   // Operating state fields
   // ----------------------------------------
   // Operating state register one edge, read capture a second edge
   AST_FSYNC_LIVE: assert property (op_rd |-> prdata[7] == $past(fs, 2))
      else $error("frame sync bit wrong");
   AST_LOCK_LIVE: assert property (op_rd |-> prdata[6] == $past(lk, 2))
      else $error("aux lock bit wrong");
   AST_STATE_LIVE: assert property (op_rd |-> prdata[2:0] == $past(st, 2))
      else $error("main loop state wrong");

   // Main scenarios
   cover property (op_rd);
   cover property (pslverr);
   cover property (pready && pwrite);
endmodule

bind tas_alarm_status_bank tas_alarm_status_bank_sva #(.NUM_CC(NUM_CC)) u_sva (
   .clk(clk),
   .rst_n(rst_n),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pready(pready),
   .prdata(prdata),
   .pslverr(pslverr),
   .loop_status(loop_status)
);

// ===== verification/tb.sv
// Self-checking bench for the alarm and status bank.
// Drives all ports itself: APB master tasks, status table, rail marks.
`timescale 1ns/1ps
module tb;
   // ----------------------------------------
   // Signals and table
   // ----------------------------------------
   typedef struct packed {
      tas_pkg::tas_loop_t lp;
      tas_pkg::tas_ref_t mr;
      tas_pkg::tas_ref_t ar;
      logic [7:0] ctl;
      logic [13:0] msk;
      logic [7:0] op;
      logic [7:0] top;
      logic [7:0] p23;
   } tas_row_t;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, noin, rde, pol;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   tas_pkg::tas_loop_t lp;
   tas_pkg::tas_ref_t mr, ar;
   logic [7:0] pe;
   logic [1:0] cp, cn, tone;
   int failures, compares;
   tas_row_t rows [6];

   tas_alarm_status_bank u_tas_alarm_status_bank (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .loop_status(lp), .main_refs(mr), .aux_refs(ar),
      .phase_error_mag(pe), .aux_loop_no_input(noin), .cc_pos(cp), .cc_neg(cn),
      .cc_tone_400hz(tone), .interrupt_request_out(irq)
   );

   // Clock of 8 ns
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rdv = prdata;
      rde = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdv, exp);
   endtask

   // Rail marks on both inputs; bpv puts a same-polarity mark every 8th
   task automatic marks(input int n, input logic bpv);
      for (int k = 0; k < n; k++)
      begin
         if (!(bpv && k % 8 == 7))
            pol = ~pol;
         cp <= pol ? 2'b11 : 2'b00;
         cn <= pol ? 2'b00 : 2'b11;
         cyc(4);
         cp <= 2'b00;
         cn <= 2'b00;
         cyc(60);
      end
   endtask

   task automatic conclude;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Watchdog against a hang
   initial
   begin
      cyc(40000);
      failures++;
      conclude;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      failures = 0;
      compares = 0;
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      lp = {1'b0, 1'b1, 8'h00, 8'h00, 3'h1};
      {mr, ar, pe, noin, cp, cn, tone, pol} = '0;
      rows[0] = {1'b0, 1'b1, 8'h00, 8'h00, 3'h1, 18'h0, 18'h0, 8'h03, 14'h3fff, 24'h410000};
      rows[1] = {1'b1, 1'b0, 8'h80, 8'h00, 3'h4, 14'h0029, 4'h4, 18'h0, 8'h03, 14'h3fff,
                 24'ha41464};
      rows[2] = {1'b0, 1'b1, 8'h00, 8'h80, 3'h7, 14'h0029, 4'h1, 18'h0, 8'h03, 14'h3ffe,
                 24'h574006};
      rows[3] = {1'b0, 1'b0, 8'h7f, 8'h7f, 3'h2, 14'h0029, 4'h4, 14'h2000, 4'he, 8'h07,
                 14'h3fff, 24'h02ee00};
      rows[4] = {1'b1, 1'b1, 8'hff, 8'hff, 3'h5, 14'h3fff, 4'hf, 18'h0, 8'h03, 14'h3fff,
                 24'hf51032};
      rows[5] = {1'b0, 1'b0, 8'h00, 8'h00, 3'h6, 18'h0, 14'h0006, 4'h3, 8'h0f, 14'h3fff,
                 24'h062303};
      cyc(5);
      rst_n <= 1'b1;
      // Reset values and refusals
      rd(12'h020, 32'h50);
      rd(12'h024, 32'h41);
      rd(12'h028, 32'h0);
      rd(12'h02c, 32'h0);
      chk({31'h0, irq}, 32'h0);
      rd(12'h030, 32'h0);
      chk({31'h0, rde}, 32'h1);
      wr(12'h021, 32'hff);
      chk({31'h0, rde}, 32'h1);
      rd(12'h020, 32'h50);
      // Live status and priority table
      foreach (rows[i])
      begin
         lp <= rows[i].lp;
         mr <= rows[i].mr;
         ar <= rows[i].ar;
         wr(12'h044, {24'h0, rows[i].ctl});
         wr(12'h048, {18'h0, rows[i].msk});
         rd(12'h024, {24'h0, rows[i].op});
         rd(12'h028, {24'h0, rows[i].top});
         rd(12'h02c, {24'h0, rows[i].p23});
      end
      // Phase alarm, no-input alarm and interrupt enable
      wr(12'h04c, 32'h7f10);
      rd(12'h04c, 32'h7f10);
      wr(12'h020, 32'hff);
      wr(12'h040, 32'h20);
      pe <= 8'h10;
      cyc(4);
      rd(12'h020, 32'h0);
      pe <= 8'h11;
      cyc(4);
      chk({31'h0, irq}, 32'h1);
      pe <= 8'h00;
      wr(12'h020, 32'h0);
      rd(12'h020, 32'h20);
      wr(12'h020, 32'h20);
      rd(12'h020, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(12'h040, 32'h10);
      pe <= 8'h11;
      cyc(4);
      chk({31'h0, irq}, 32'h0);
      noin <= 1'b1;
      cyc(4);
      chk({31'h0, irq}, 32'h1);
      wr(12'h020, 32'h30);
      rd(12'h020, 32'h10);
      noin <= 1'b0;
      wr(12'h020, 32'h10);
      rd(12'h020, 32'h0);
      // Composite-clock line code
      wr(12'h040, 32'h0f);
      wr(12'h044, 32'h00);
      marks(24, 1'b1);
      wr(12'h020, 32'hff);
      rd(12'h020, 32'h0);
      tone <= 2'b11;
      cyc(8);
      marks(24, 1'b0);
      cyc(8);
      rd(12'h020, 32'h0);
      tone <= 2'b00;
      wr(12'h044, 32'h02);
      marks(24, 1'b0);
      cyc(8);
      rd(12'h020, 32'h02);
      chk({31'h0, irq}, 32'h1);
      wr(12'h020, 32'h02);
      marks(24, 1'b1);
      cyc(8);
      rd(12'h020, 32'h0);
      // Loss of signal on input a
      cyc(3400);
      rd(12'h020, 32'h0);
      cyc(700);
      rd(12'h020, 32'h01);
      wr(12'h020, 32'h01);
      cyc(100);
      rd(12'h020, 32'h0);
      conclude;
   end
endmodule
